// ### llpm_pkg.sv
package llpm_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTL_BASE = 12'h000;
  localparam logic [11:0] CTL_STRIDE = 12'h010;
  localparam logic [11:0] OFS_CTL_LO = 12'h000;
  localparam logic [11:0] OFS_CTL_HI = 12'h004;
  localparam logic [11:0] OFS_CNT_LO = 12'h008;
  localparam logic [11:0] OFS_CNT_HI = 12'h00c;
  localparam logic [31:0] CTL_LO_RESET = 32'h0000_0000;
  localparam logic [23:0] EXT_RESET = 24'h00_0000;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int EVSEL_LSB = 0;
  localparam int EVSEL_MSB = 7;
  localparam int OPC_LSB = 12;
  localparam int OPC_MSB = 15;
  localparam int EXT_MSB = 55;
  localparam int EXT_LSB = 32;
  // Extension bits, relative to bit 32
  localparam int X_IMPLNULL = 23;
  localparam int X_NONZERO = 22;
  localparam int X_SLOT_MSB = 21;
  localparam int X_SLOT_LSB = 19;
  localparam int X_EN_SRCID = 18;
  localparam int X_SRCID_MSB = 17;
  localparam int X_SRCID_LSB = 14;
  localparam int X_EN_DSTID = 13;
  localparam int X_DSTID_MSB = 11;
  localparam int X_DSTID_LSB = 8;
  localparam int X_ISOCH = 7;
  localparam int X_SGLSLOT = 6;
  localparam int X_DUALSLOT = 5;
  localparam int X_NONDATA = 4;
  localparam int X_DATA = 3;
  localparam int X_REMOTE = 2;
  localparam int X_LOCAL = 1;
  localparam int X_OPC = 0;
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_ALL = 3'h7;
  // ----------------------------------------------------------------
  // Event codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EV_CLOCK_TICK = 8'h01;
  localparam logic [7:0] EV_TX_HDR_MATCH = 8'h04;
  localparam logic [7:0] EV_RX_HDR_MATCH = 8'h05;
  localparam logic [7:0] EV_PHY_INIT = 8'h20;
  localparam logic [7:0] EV_SHUTDOWN_CYCLES = 8'h21;
  localparam logic [7:0] EV_SHUTDOWN_ACCEPT = 8'h22;
  localparam logic [7:0] EV_SHUTDOWN_REFUSE = 8'h23;
  localparam logic [7:0] EV_RX_ALLOC = 8'h30;
  localparam logic [7:0] EV_RX_BYPASS = 8'h31;
  localparam logic [7:0] EV_RX_FILL = 8'h32;
  localparam logic [7:0] EV_TX_ALLOC = 8'h40;
  localparam logic [7:0] EV_TX_BYPASS = 8'h41;
  localparam logic [7:0] EV_TX_FILL = 8'h42;
  localparam logic [7:0] EV_CREDIT_PENDING = 8'h44;
  // Physical layer power states
  localparam logic [1:0] PWR_FULL = 2'h0;
  localparam logic [1:0] PWR_IDLE = 2'h1;
  localparam logic [1:0] PWR_HALF = 2'h2;
  localparam logic [1:0] PWR_SHUTDOWN = 2'h3;
  // Increment limits
  localparam logic [8:0] MAX_SLOT_INC = 9'h003;
  localparam logic [8:0] MAX_RX_FILL = 9'h080;
  localparam logic [8:0] MAX_TX_FILL = 9'h020;
  localparam logic [8:0] MAX_CREDIT = 9'h080;
endpackage : llpm_pkg

// ### llpm_slot_match.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------------
// Header matcher for one flit slot
// --------------------------------------------------------------------
module llpm_slot_match #(
  parameter int SLOT = 0
) (
  // Configuration
  input wire logic [23:0] ext,
  input wire logic [3:0] opcode_sel,
  input wire logic rx_dir,
  // Header fields
  input wire logic hdr_valid,
  input wire logic [3:0] hdr_opcode,
  input wire logic [3:0] hdr_src_id,
  input wire logic [3:0] hdr_dst_id,
  input wire logic hdr_isoch,
  input wire logic hdr_dual,
  input wire logic hdr_data,
  input wire logic hdr_remote,
  input wire logic hdr_implnull,
  input wire logic hdr_nonzero,
  // Result
  output logic hit
);
  logic [2:0] slots;
  logic slot_on;
  logic ok_id;
  logic ok_kind;
  logic ok_loc;
  logic ok_opc;

  always_comb begin
    slots = ext[llpm_pkg::X_SLOT_MSB:llpm_pkg::X_SLOT_LSB];
    if (slots == llpm_pkg::SLOT_NONE) begin
      slots = llpm_pkg::SLOT_ALL;
    end
    slot_on = slots[SLOT];
    ok_id = !ext[llpm_pkg::X_EN_SRCID] ||
      (hdr_src_id == ext[llpm_pkg::X_SRCID_MSB:llpm_pkg::X_SRCID_LSB]);
    ok_id = ok_id && (!ext[llpm_pkg::X_EN_DSTID] ||
      (hdr_dst_id == ext[llpm_pkg::X_DSTID_MSB:llpm_pkg::X_DSTID_LSB]));
    ok_kind = (!ext[llpm_pkg::X_ISOCH] || hdr_isoch) &&
      (!ext[llpm_pkg::X_SGLSLOT] || !hdr_dual) &&
      (!ext[llpm_pkg::X_DUALSLOT] || hdr_dual);
    ok_kind = ok_kind && (!ext[llpm_pkg::X_NONDATA] || !hdr_data) &&
      (!ext[llpm_pkg::X_DATA] || hdr_data);
    ok_loc = !rx_dir ||
      ((!ext[llpm_pkg::X_REMOTE] || hdr_remote) &&
       (!ext[llpm_pkg::X_LOCAL] || !hdr_remote));
    ok_opc = !ext[llpm_pkg::X_OPC] || (hdr_opcode == opcode_sel);
    // credit qualifiers on third slot only
    if (SLOT == 2 && ext[llpm_pkg::X_OPC]) begin
      ok_opc = ok_opc && (!ext[llpm_pkg::X_IMPLNULL] || hdr_implnull) &&
        (!ext[llpm_pkg::X_NONZERO] || hdr_nonzero);
    end
    hit = hdr_valid && slot_on && ok_id && ok_kind && ok_loc && ok_opc;
  end
endmodule // llpm_slot_match
`default_nettype wire

// ### llpm_counters.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module llpm_counters #(
  parameter int NUM_CTR = 4,
  parameter int CTR_W = 48
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Transmit headers, three slots
  input wire logic [2:0] TX_HDR_VALID,
  input wire logic [11:0] TX_HDR_OPCODE,
  input wire logic [11:0] TX_HDR_SRC_ID,
  input wire logic [11:0] TX_HDR_DST_ID,
  input wire logic [2:0] TX_HDR_ISOCH,
  input wire logic [2:0] TX_HDR_DUAL,
  input wire logic [2:0] TX_HDR_DATA,
  input wire logic [2:0] TX_HDR_REMOTE,
  input wire logic [2:0] TX_HDR_IMPLNULL,
  input wire logic [2:0] TX_HDR_NONZERO,
  // Receive headers, three slots
  input wire logic [2:0] RX_HDR_VALID,
  input wire logic [11:0] RX_HDR_OPCODE,
  input wire logic [11:0] RX_HDR_SRC_ID,
  input wire logic [11:0] RX_HDR_DST_ID,
  input wire logic [2:0] RX_HDR_ISOCH,
  input wire logic [2:0] RX_HDR_DUAL,
  input wire logic [2:0] RX_HDR_DATA,
  input wire logic [2:0] RX_HDR_REMOTE,
  input wire logic [2:0] RX_HDR_IMPLNULL,
  input wire logic [2:0] RX_HDR_NONZERO,
  // Power and buffer activity
  input wire logic [1:0] PHY_POWER_STATE,
  input wire logic PHY_POWER_VALID,
  input wire logic SHUTDOWN_ACCEPTED,
  input wire logic SHUTDOWN_REFUSED,
  input wire logic [1:0] RX_ALLOC_COUNT,
  input wire logic [1:0] RX_BYPASS_COUNT,
  input wire logic [7:0] RX_FILL_LEVEL,
  input wire logic TX_ALLOC,
  input wire logic TX_BYPASS,
  input wire logic [5:0] TX_FILL_LEVEL,
  input wire logic [7:0] CREDIT_PENDING
);
  // ----------------------------------------------------------------
  // Control and counter state
  // ----------------------------------------------------------------
  logic [31:0] ctl_lo [NUM_CTR];
  logic [23:0] ctl_ext [NUM_CTR];
  logic [CTR_W-1:0] count [NUM_CTR];
  logic [2:0] tx_hit [NUM_CTR];
  logic [2:0] rx_hit [NUM_CTR];
  logic [8:0] inc [NUM_CTR];
  logic [23:0] eff_ext [NUM_CTR];
  logic [1:0] acc_reg;
  logic [1:0] acc_ctr;
  logic acc_ok;
  logic wr_en;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    acc_reg = PADDR[3:2];
    acc_ctr = PADDR[5:4];
    acc_ok = (PADDR[11:6] == llpm_pkg::CTL_BASE[11:6]) && (PADDR[1:0] == 2'h0) &&
      (32'(acc_ctr) < NUM_CTR);
    wr_en = PSEL && PENABLE && PWRITE && acc_ok;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc_ok) begin
      case ({acc_reg, 2'h0})
        4'(llpm_pkg::OFS_CTL_LO): next_rdata = ctl_lo[acc_ctr];
        4'(llpm_pkg::OFS_CTL_HI): next_rdata = {8'h00, ctl_ext[acc_ctr]};
        4'(llpm_pkg::OFS_CNT_LO): next_rdata = count[acc_ctr][31:0];
        4'(llpm_pkg::OFS_CNT_HI): next_rdata = 32'(count[acc_ctr][CTR_W-1:32]);
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !acc_ok;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-counter logic
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
    logic wr_here;
    logic is_match;
    assign wr_here = wr_en && PREADY && (acc_ctr == 2'(c));

    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        ctl_lo[c] <= llpm_pkg::CTL_LO_RESET;
        ctl_ext[c] <= llpm_pkg::EXT_RESET;
      end else if (wr_here && acc_reg == llpm_pkg::OFS_CTL_LO[3:2]) begin
        ctl_lo[c] <= PWDATA;
      end else if (wr_here && acc_reg == llpm_pkg::OFS_CTL_HI[3:2]) begin
        ctl_ext[c] <= PWDATA[23:0];
      end
    end

    always_comb begin
      is_match = (ctl_lo[c][llpm_pkg::EVSEL_MSB:llpm_pkg::EVSEL_LSB] ==
        llpm_pkg::EV_TX_HDR_MATCH) ||
        (ctl_lo[c][llpm_pkg::EVSEL_MSB:llpm_pkg::EVSEL_LSB] == llpm_pkg::EV_RX_HDR_MATCH);
      eff_ext[c] = is_match ? ctl_ext[c] : 24'h00_0000;
    end

    for (genvar s = 0; s < 3; s++) begin : g_slot
      llpm_slot_match #(.SLOT(s)) u_tx (
        .ext(eff_ext[c]),
        .opcode_sel(ctl_lo[c][llpm_pkg::OPC_MSB:llpm_pkg::OPC_LSB]),
        .rx_dir(1'b0),
        .hdr_valid(TX_HDR_VALID[s]),
        .hdr_opcode(TX_HDR_OPCODE[4*s +: 4]),
        .hdr_src_id(TX_HDR_SRC_ID[4*s +: 4]),
        .hdr_dst_id(TX_HDR_DST_ID[4*s +: 4]),
        .hdr_isoch(TX_HDR_ISOCH[s]),
        .hdr_dual(TX_HDR_DUAL[s]),
        .hdr_data(TX_HDR_DATA[s]),
        .hdr_remote(TX_HDR_REMOTE[s]),
        .hdr_implnull(TX_HDR_IMPLNULL[s]),
        .hdr_nonzero(TX_HDR_NONZERO[s]),
        .hit(tx_hit[c][s])
      );
      llpm_slot_match #(.SLOT(s)) u_rx (
        .ext(eff_ext[c]),
        .opcode_sel(ctl_lo[c][llpm_pkg::OPC_MSB:llpm_pkg::OPC_LSB]),
        .rx_dir(1'b1),
        .hdr_valid(RX_HDR_VALID[s]),
        .hdr_opcode(RX_HDR_OPCODE[4*s +: 4]),
        .hdr_src_id(RX_HDR_SRC_ID[4*s +: 4]),
        .hdr_dst_id(RX_HDR_DST_ID[4*s +: 4]),
        .hdr_isoch(RX_HDR_ISOCH[s]),
        .hdr_dual(RX_HDR_DUAL[s]),
        .hdr_data(RX_HDR_DATA[s]),
        .hdr_remote(RX_HDR_REMOTE[s]),
        .hdr_implnull(RX_HDR_IMPLNULL[s]),
        .hdr_nonzero(RX_HDR_NONZERO[s]),
        .hit(rx_hit[c][s])
      );
    end

    always_comb begin
      case (ctl_lo[c][llpm_pkg::EVSEL_MSB:llpm_pkg::EVSEL_LSB])
        llpm_pkg::EV_CLOCK_TICK: inc[c] = 9'h001;
        llpm_pkg::EV_TX_HDR_MATCH:
          inc[c] = 9'(tx_hit[c][0]) + 9'(tx_hit[c][1]) + 9'(tx_hit[c][2]);
        llpm_pkg::EV_RX_HDR_MATCH:
          inc[c] = 9'(rx_hit[c][0]) + 9'(rx_hit[c][1]) + 9'(rx_hit[c][2]);
        llpm_pkg::EV_PHY_INIT: inc[c] = 9'(!PHY_POWER_VALID);
        llpm_pkg::EV_SHUTDOWN_CYCLES:
          inc[c] = 9'(PHY_POWER_VALID && PHY_POWER_STATE == llpm_pkg::PWR_SHUTDOWN);
        llpm_pkg::EV_SHUTDOWN_ACCEPT: inc[c] = 9'(SHUTDOWN_ACCEPTED);
        llpm_pkg::EV_SHUTDOWN_REFUSE: inc[c] = 9'(SHUTDOWN_REFUSED);
        llpm_pkg::EV_RX_ALLOC: inc[c] = 9'(RX_ALLOC_COUNT);
        llpm_pkg::EV_RX_BYPASS: inc[c] = 9'(RX_BYPASS_COUNT);
        llpm_pkg::EV_RX_FILL: inc[c] = (9'(RX_FILL_LEVEL) > llpm_pkg::MAX_RX_FILL) ?
          llpm_pkg::MAX_RX_FILL : 9'(RX_FILL_LEVEL);
        llpm_pkg::EV_TX_ALLOC: inc[c] = 9'(TX_ALLOC);
        llpm_pkg::EV_TX_BYPASS: inc[c] = 9'(TX_BYPASS);
        llpm_pkg::EV_TX_FILL: inc[c] = (9'(TX_FILL_LEVEL) > llpm_pkg::MAX_TX_FILL) ?
          llpm_pkg::MAX_TX_FILL : 9'(TX_FILL_LEVEL);
        llpm_pkg::EV_CREDIT_PENDING: inc[c] = (9'(CREDIT_PENDING) > llpm_pkg::MAX_CREDIT) ?
          llpm_pkg::MAX_CREDIT : 9'(CREDIT_PENDING);
        default: inc[c] = 9'h000;
      endcase
    end

    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        count[c] <= '0;
      end else if (wr_here && acc_reg == llpm_pkg::OFS_CNT_LO[3:2]) begin
        count[c] <= {count[c][CTR_W-1:32], PWDATA};
      end else if (wr_here && acc_reg == llpm_pkg::OFS_CNT_HI[3:2]) begin
        count[c] <= {PWDATA[CTR_W-33:0], count[c][31:0]};
      end else begin
        count[c] <= count[c] + CTR_W'(inc[c]);
      end
    end
  end
endmodule // llpm_counters
`default_nettype wire

// ### llpm_counters_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Register port checks
// ----
module llpm_counters_checker #(
  parameter int NUM_CTR = 4,
  parameter int CTR_W = 48
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  logic done;
  logic bad;
  logic rd_ok;
  assign done = PSEL && PENABLE && PREADY;
  assign bad = (PADDR >= 12'(NUM_CTR * 16)) || (PADDR[1:0] != 2'h0);
  assign rd_ok = done && !bad && !PWRITE;
  setup_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  bad_addr_err_a: assert property (done && bad |-> PSLVERR)
    else $error("no error flag");
  good_addr_ok_a: assert property (done && !bad |-> !PSLVERR)
    else $error("false error flag");
  err_read_zero_a: assert property (done && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("error read not zero");
  ext_top_zero_a: assert property (rd_ok && PADDR[3:0] == 4'h4 |-> PRDATA[31:24] == 8'h0)
    else $error("reserved bits set");
  count_top_zero_a: assert property (rd_ok && PADDR[3:0] == 4'hc |->
    (PRDATA >> (CTR_W - 32)) == 32'h0) else $error("count too wide");
  cover property (done && PWRITE && !bad);
  cover property (rd_ok);
  cover property (done && PSLVERR);
endmodule // llpm_counters_checker
bind llpm_counters llpm_counters_checker #(.NUM_CTR(NUM_CTR), .CTR_W(CTR_W))
  llpm_counters_checker_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// ### llpm_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Software side of the register bus
// ----
module llpm_sw_model (
  // Clock
  input wire logic clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable, paddr, pwdata} <= {2'h0, ~a, ~wd};
    if (i == 16) begin
      $display("wrong value at %0t: no ready", $time);
      llpm_counters_tb.n_errors++;
      llpm_counters_tb.conclude();
    end
  endtask
  task automatic set_ctl(input logic [1:0] n, input logic [7:0] ev, input logic [3:0] opc,
                         input logic [23:0] ext);
    logic [31:0] w [4];
    logic [31:0] d;
    logic e;
    int k;
    w = '{{16'h0, opc, 4'h0, ev}, {8'h0, ext}, 32'h0, 32'h0};
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, llpm_pkg::CTL_STRIDE * {10'h0, n} + 12'(4 * k), w[k], d, e);
    end
  endtask
endmodule // llpm_sw_model
`default_nettype wire

// ### llpm_counters_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Counter block bench
// ----
module llpm_counters_tb;
  localparam int K = 4;
  localparam logic [7:0] EV [20] = '{8'h04, 8'h04, 8'h04, 8'h05, 8'h05, 8'h05, 8'h32, 8'h20,
    8'h42, 8'h44, 8'h30, 8'h23, 8'h04, 8'h41, 8'h31, 8'h22, 8'h05, 8'h04, 8'h04, 8'h05};
  localparam logic [23:0] EXT [20] = '{24'h0, 24'h100000, 24'h054000, 24'h0, 24'h000001,
    24'h002900, 24'h0, 24'h0, 24'h0, 24'h0, 24'h054000, 24'h0, 24'hc80000, 24'h0, 24'h0,
    24'h0, 24'h000004, 24'h000002, 24'h000048, 24'h400001};
  localparam logic [8:0] PER [20] = '{9'h3, 9'h1, 9'h2, 9'h3, 9'h2, 9'h1, 9'h80, 9'h1,
    9'h20, 9'h80, 9'h3, 9'h1, 9'h1, 9'h1, 9'h2, 9'h1, 9'h2, 9'h3, 9'h2, 9'h2};
  int n_errors = 0;
  int samples_checked = 0;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] tx_v, tx_iso, tx_dual, tx_data, tx_rem, tx_null, tx_nz;
  logic [2:0] rx_v, rx_iso, rx_dual, rx_data, rx_rem, rx_null, rx_nz;
  logic [11:0] tx_opc, tx_src, tx_dst, rx_opc, rx_src, rx_dst;
  logic [1:0] pwr_st, rx_alloc, rx_byp;
  logic pwr_ok, sd_acc, sd_ref, tx_alloc, tx_byp;
  logic [7:0] rx_fill, credit;
  logic [5:0] tx_fill;
  always #2.5 clk_sys = ~clk_sys;
  llpm_counters #(.NUM_CTR(4), .CTR_W(48)) llpm_counters_i (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_HDR_VALID(tx_v), .TX_HDR_OPCODE(tx_opc), .TX_HDR_SRC_ID(tx_src),
    .TX_HDR_DST_ID(tx_dst), .TX_HDR_ISOCH(tx_iso), .TX_HDR_DUAL(tx_dual),
    .TX_HDR_DATA(tx_data), .TX_HDR_REMOTE(tx_rem), .TX_HDR_IMPLNULL(tx_null),
    .TX_HDR_NONZERO(tx_nz), .RX_HDR_VALID(rx_v), .RX_HDR_OPCODE(rx_opc),
    .RX_HDR_SRC_ID(rx_src), .RX_HDR_DST_ID(rx_dst), .RX_HDR_ISOCH(rx_iso),
    .RX_HDR_DUAL(rx_dual), .RX_HDR_DATA(rx_data), .RX_HDR_REMOTE(rx_rem),
    .RX_HDR_IMPLNULL(rx_null), .RX_HDR_NONZERO(rx_nz), .PHY_POWER_STATE(pwr_st),
    .PHY_POWER_VALID(pwr_ok), .SHUTDOWN_ACCEPTED(sd_acc), .SHUTDOWN_REFUSED(sd_ref),
    .RX_ALLOC_COUNT(rx_alloc), .RX_BYPASS_COUNT(rx_byp), .RX_FILL_LEVEL(rx_fill),
    .TX_ALLOC(tx_alloc), .TX_BYPASS(tx_byp), .TX_FILL_LEVEL(tx_fill), .CREDIT_PENDING(credit));
  llpm_sw_model llpm_sw_model_i (.clk(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic drive(input logic on);
    {tx_v, tx_src, tx_dst, tx_opc, tx_iso, tx_dual, tx_data, tx_rem, tx_null, tx_nz} <= on ?
      {3'h7, 12'h535, 12'h123, 12'h777, 3'h1, 3'h2, 3'h5, 3'h7, 3'h6, 3'h6} : '0;
    {rx_v, rx_opc, rx_dst, rx_src, rx_iso, rx_dual, rx_data, rx_rem, rx_null, rx_nz} <= on ?
      {3'h7, 12'hbaa, 12'h009, 12'h321, 3'h4, 3'h2, 3'h1, 3'h3, 3'h5, 3'h5} : '0;
    {sd_ref, sd_acc, rx_fill, tx_fill, credit, rx_alloc, rx_byp, tx_alloc, tx_byp, pwr_st} <=
      on ? {2'h3, 8'h80, 6'h20, 8'h80, 2'h3, 2'h2, 2'h3, 2'h3} : '0;
    pwr_ok <= !on;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e);
    llpm_sw_model_i.xfer(1'b0, a, 32'h0, d, e);
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] d;
    logic [31:0] d0;
    logic e;
    int i;
    int p;
    drive(1'b0);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd(12'h030 + 12'(4 * i), d, e);
      chk({e, d}, 33'h0);
    end
    rd(12'h040, d, e);
    chk({e, d}, {1'b1, 32'h0});
    llpm_sw_model_i.xfer(1'b1, 12'h012, 32'h1, d, e);
    chk({e, 32'h0}, {1'b1, 32'h0});
    rd(12'h010, d, e);
    chk({e, d}, 33'h0);
    llpm_sw_model_i.set_ctl(2'h0, 8'h04, 4'h0, 24'h0);
    llpm_sw_model_i.xfer(1'b1, 12'h004, 32'hffff_ffff, d, e);
    rd(12'h004, d, e);
    chk({e, d}, {1'b0, 32'h00ff_ffff});
    for (p = 0; p < 20; p += 4) begin
      for (i = 0; i < 4; i++) begin
        llpm_sw_model_i.set_ctl(2'(i), EV[p + i], 4'ha, EXT[p + i]);
      end
      @(posedge clk_sys);
      drive(1'b1);
      repeat (K) @(posedge clk_sys);
      drive(1'b0);
      for (i = 0; i < 4; i++) begin
        rd(12'h008 + 12'(16 * i), d, e);
        chk({e, d}, {1'b0, 32'(PER[p + i]) * K});
      end
    end
    llpm_sw_model_i.set_ctl(2'h1, 8'h01, 4'h0, 24'h0);
    rd(12'h018, d0, e);
    repeat (10) @(posedge clk_sys);
    rd(12'h018, d, e);
    chk({e, d - d0}, {1'b0, 32'd13});
    llpm_sw_model_i.set_ctl(2'h2, 8'h21, 4'h0, 24'h0);
    llpm_sw_model_i.set_ctl(2'h3, 8'h40, 4'h0, 24'h0);
    @(posedge clk_sys);
    pwr_st <= 2'h3;
    tx_alloc <= 1'b1;
    repeat (K) @(posedge clk_sys);
    pwr_st <= 2'h0;
    tx_alloc <= 1'b0;
    rd(12'h028, d, e);
    chk({e, d}, {1'b0, 32'(K)});
    rd(12'h038, d, e);
    chk({e, d}, {1'b0, 32'(K)});
    conclude();
  end
endmodule // llpm_counters_tb
`default_nettype wire
